// [rtl/tcp_test_ctl.sv]
`timescale 1ns/10ps
// Purpose: test cell / pattern control and status register with generator
// Assumes: classic wishbone, 32-bit data, one register, ack one cycle later
// Notes:   generator runs one payload bit per clock; cell is 48 bytes
module tcp_test_ctl (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_pattern_in,
  input  wire logic        rx_pattern_valid,
  input  wire logic        tx_serial_payload_in,
  output logic             tx_pattern_out,
  output logic             tx_pattern_valid,
  output logic             cell_start,
  output logic             overhead_take,
  output logic             overhead_bit,
  output logic             error_event,
  output logic [15:0]      error_count
);

  tcp_ctl_if ctl ();

  logic [7:0]   csr_q;
  logic         en_prev_q;
  tcp_pkg::tcp_gen_e state_q;
  tcp_pkg::tcp_gen_e state_d;
  logic [10:0]  cells_q;
  logic [5:0]   byte_q;
  logic [2:0]   bitc_q;
  logic [14:0]  lfsr_q;
  logic         ack_q;
  logic [31:0]  rdat_q;
  logic         tx_bit_q;
  logic         tx_vld_q;
  logic         cstart_q;
  logic         oh_take_q;
  logic         oh_bit_q;
  logic         err_ev_q;
  logic [15:0]  err_cnt_q;
  logic         ser_m_q;
  logic         ser_s_q;
  logic         rxb_m_q;
  logic         rxb_s_q;
  logic         rxv_m_q;
  logic         rxv_s_q;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  wire logic   req      = wb_cyc_i & wb_stb_i & ~ack_q;
  wire logic   hit      = (wb_adr_i == tcp_pkg::CSR_ADDR);
  wire logic   wr_csr   = req & wb_we_i & hit & wb_sel_i[0];
  wire logic [7:0] wr_val =
    (wb_dat_i[7:0] & tcp_pkg::WR_MASK) | (csr_q & ~tcp_pkg::WR_MASK);

  // ****************************************************************
  // control field decode
  // ****************************************************************
  // mode select
  wire logic   clear_md = csr_q[tcp_pkg::BIT_MODE];
  wire logic   enable   = csr_q[tcp_pkg::BIT_ENABLE];
  wire logic   burst_md = csr_q[tcp_pkg::BIT_BURST] & ~clear_md;
  wire logic   en_rise  = enable & ~en_prev_q;
  wire logic   last_bit = (bitc_q == 3'h7);
  wire logic   last_byt = (byte_q == tcp_pkg::CELL_BYTES - 6'h1);
  wire logic   cell_end = last_bit & last_byt;
  wire logic   running  = (state_q == tcp_pkg::TCP_RUN);
  wire logic   lfsr_fb  = lfsr_q[14] ^ lfsr_q[13];
  // done meaningful only in burst cell mode
  wire logic   done_bit = burst_md & (state_q == tcp_pkg::TCP_DONE);
  wire logic [7:0] rd_val = {csr_q[7:6], 1'b0, csr_q[4:2],
                             done_bit, ctl.locked};

  // one enable drives both generator and receiver in either mode
  assign ctl.gen_en   = running;
  assign ctl.rx_en    = enable;
  assign ctl.clear_md = clear_md;

  // ****************************************************************
  // generator state machine
  // ****************************************************************
  // a write that turns enable off wins immediately over the burst count
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      tcp_pkg::TCP_IDLE: begin
        if (enable) begin
          state_d = tcp_pkg::TCP_RUN;
        end
      end
      tcp_pkg::TCP_RUN: begin
        if (!enable) begin
          state_d = tcp_pkg::TCP_IDLE;
        end else if (burst_md && cell_end &&
                     cells_q == tcp_pkg::BURST_CELLS - 11'h1) begin
          state_d = tcp_pkg::TCP_DONE;
        end
      end
      tcp_pkg::TCP_DONE: begin
        if (en_rise) begin
          state_d = tcp_pkg::TCP_RUN;
        end else if (!burst_md) begin
          state_d = enable ? tcp_pkg::TCP_RUN : tcp_pkg::TCP_IDLE;
        end
      end
      default: state_d = tcp_pkg::TCP_IDLE;
    endcase
  end

  // state, register and enable history
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q   <= tcp_pkg::TCP_IDLE;
      csr_q     <= tcp_pkg::CSR_RESET;
      en_prev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      csr_q     <= wr_csr ? wr_val : csr_q;
      en_prev_q <= enable;
    end
  end

  // ****************************************************************
  // cell, byte and bit counters with payload sequence
  // ****************************************************************
  // continuous run
  always_ff @(posedge clock) begin
    if (srst || state_d != tcp_pkg::TCP_RUN || en_rise) begin
      cells_q <= tcp_pkg::CNT_RESET;
      byte_q  <= tcp_pkg::BYTE_RESET;
      bitc_q  <= 3'h0;
      lfsr_q  <= tcp_pkg::LFSR_SEED;
    end else if (running) begin
      bitc_q <= bitc_q + 3'h1;
      lfsr_q <= {lfsr_q[13:0], lfsr_fb};
      if (last_bit) begin
        byte_q <= last_byt ? tcp_pkg::BYTE_RESET : byte_q + 6'h1;
      end
      // count wraps harmlessly in continuous mode
      if (cell_end) begin
        cells_q <= cells_q + 11'h1;
      end
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clock) begin
    ser_m_q <= tx_serial_payload_in;
    ser_s_q <= ser_m_q;
    rxb_m_q <= rx_pattern_in;
    rxb_s_q <= rxb_m_q;
    rxv_m_q <= rx_pattern_valid;
    rxv_s_q <= rxv_m_q;
  end

  // ****************************************************************
  // stream outputs
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_bit_q  <= 1'b0;
      tx_vld_q  <= 1'b0;
      cstart_q  <= 1'b0;
      oh_take_q <= 1'b0;
      oh_bit_q  <= 1'b0;
    end else begin
      tx_bit_q  <= running & lfsr_fb;
      tx_vld_q  <= running;
      cstart_q  <= running & (bitc_q == 3'h0) &
                   (byte_q == tcp_pkg::BYTE_RESET);
      oh_take_q <= csr_q[tcp_pkg::BIT_OH_IN] & ~clear_md;
      oh_bit_q  <= csr_q[tcp_pkg::BIT_OH_IN] & ~clear_md & ser_s_q;
    end
  end

  // ****************************************************************
  // error accounting
  // ****************************************************************
  // count only locked errors
  always_ff @(posedge clock) begin
    if (srst || en_rise) begin
      err_ev_q  <= 1'b0;
      err_cnt_q <= tcp_pkg::ERR_RESET;
    end else begin
      err_ev_q  <= ctl.err_pulse;
      if (ctl.err_pulse && err_cnt_q != 16'hFFFF) begin
        err_cnt_q <= err_cnt_q + 16'h0001; // saturates, no wrap
      end
    end
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  // unmapped addresses still ack and read zero, writes dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= req;
      rdat_q <= (req && hit) ? {24'h00_0000, rd_val} : 32'h0000_0000;
    end
  end

  tcp_pattern_rx u_rx (
    .clock    (clock),
    .srst     (srst),
    .rx_bit   (rxb_s_q),
    .rx_valid (rxv_s_q),
    .ctl      (ctl.pat)
  );

  assign wb_ack_o         = ack_q;
  assign wb_dat_o         = rdat_q;
  assign tx_pattern_out   = tx_bit_q;
  assign tx_pattern_valid = tx_vld_q;
  assign cell_start       = cstart_q;
  assign overhead_take    = oh_take_q;
  assign overhead_bit     = oh_bit_q;
  assign error_event      = err_ev_q;
  assign error_count      = err_cnt_q;

endmodule : tcp_test_ctl

// [rtl/tcp_pkg.sv]
// Purpose: constants for the test cell / pattern control and status block
// Assumes: classic wishbone slave with 32-bit data, byte register in lane 0
// Notes:   offset, field positions, resets and counts live here; bit counter and read-back packing use literals
package tcp_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  CSR_ADDR      = 8'h18; // byte address of index 6
  localparam logic [7:0]  CSR_RESET     = 8'h00;
  localparam int          BIT_MODE      = 7;
  localparam int          BIT_OH_IN     = 6;
  localparam int          BIT_UNUSED    = 5;
  localparam int          BIT_ENABLE    = 4;
  localparam int          BIT_RSVD      = 3;
  localparam int          BIT_BURST     = 2;
  localparam int          BIT_DONE      = 1;
  localparam int          BIT_LOCK      = 0;
  localparam logic [7:0]  WR_MASK       = 8'hDC; // writable bits 7,6,4,3,2

  // ****************************************************************
  // generator and receiver
  // ****************************************************************
  localparam logic [10:0] BURST_CELLS   = 11'h400; // 1024 cells
  localparam logic [10:0] CNT_RESET     = 11'h000;
  localparam logic [5:0]  CELL_BYTES    = 6'h30;   // payload bytes per cell
  localparam logic [5:0]  BYTE_RESET    = 6'h00;
  localparam logic [14:0] LFSR_SEED     = 15'h7FFF;
  localparam logic [3:0]  LOCK_RUN      = 4'hF;    // good bits before the one that locks
  localparam logic [3:0]  RUN_RESET     = 4'h0;
  localparam logic [15:0] ERR_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    TCP_IDLE  = 3'b001,
    TCP_RUN   = 3'b010,
    TCP_DONE  = 3'b100
  } tcp_gen_e;

endpackage : tcp_pkg

// [rtl/tcp_ctl_if.sv]
`timescale 1ns/10ps
// Purpose: control bundle between the register block and the pattern parts
// Assumes: single clock domain
// Notes:   ctl side drives enables, pattern side reports status
interface tcp_ctl_if;
  logic       gen_en;   // generator may run
  logic       rx_en;    // receiver may search for lock
  logic       clear_md; // clear-channel mode
  logic       locked;   // receiver has lock
  logic       err_pulse;// one bit error after lock

  modport ctl (output gen_en, output rx_en, output clear_md,
               input locked, input err_pulse);
  modport pat (input gen_en, input rx_en, input clear_md,
               output locked, output err_pulse);
endinterface : tcp_ctl_if

// [rtl/tcp_pattern_rx.sv]
`timescale 1ns/10ps
// Purpose: pattern receiver, self-synchronising 15-bit sequence checker
// Assumes: rx_bit valid each cycle rx_valid is high, same clock
// Notes:   lock after a run of good bits; lock lost only when disabled
module tcp_pattern_rx (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic rx_bit,
  input  wire logic rx_valid,
  tcp_ctl_if.pat    ctl
);

  logic [14:0] hist_q;
  logic [3:0]  run_q;
  logic        lock_q;
  logic        err_q;
  wire logic   pred_bit = hist_q[14] ^ hist_q[13];
  wire logic   bit_ok   = (pred_bit == rx_bit);
  wire logic   take     = ctl.rx_en & rx_valid;

  // ****************************************************************
  // history, run counter and lock
  // ****************************************************************
  // history self-seeds from the incoming stream, so no seed alignment
  always_ff @(posedge clock) begin
    if (srst || !ctl.rx_en) begin
      hist_q <= tcp_pkg::LFSR_SEED;
      run_q  <= tcp_pkg::RUN_RESET;
      lock_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      err_q <= 1'b0;
      if (take) begin
        hist_q <= {hist_q[13:0], rx_bit};
        if (!lock_q) begin
          run_q  <= bit_ok ? run_q + 4'h1 : tcp_pkg::RUN_RESET;
          lock_q <= bit_ok && (run_q == tcp_pkg::LOCK_RUN);
        end
        err_q <= lock_q & ~bit_ok;
      end
    end
  end

  assign ctl.locked    = lock_q;
  assign ctl.err_pulse = err_q;

endmodule : tcp_pattern_rx

// [test/tcp_test_ctl_chk.sv]
// Purpose: port assertions for the test control block
// Assumes: ack comes one cycle after the request edge
// Notes:   shadow of the control bits moves at the ack edge, one late
`timescale 1ns/10ps
module tcp_test_ctl_chk (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tx_pattern_valid,
  input wire logic        overhead_take,
  input wire logic        error_event
);
  // ****************************************************************
  // shadow and assertions
  // ****************************************************************
  logic sh_wr;
  logic [7:0] sh_q;
  assign sh_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
               & (wb_adr_i == tcp_pkg::CSR_ADDR);
  // shadow lags the design so checks below allow up to two cycles of slack
  always_ff @(posedge clock) begin
    if (srst) sh_q <= 8'h00;
    else if (sh_wr) sh_q <= wb_dat_i[7:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("ack missing after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_zero: assert property (wb_ack_o && !wb_we_i |->
    wb_dat_o[31:8] == 24'h0 && !wb_dat_o[5]) else $error("bits not zero");
  a_done_mode: assert property (wb_ack_o && !wb_we_i && wb_dat_o[1] |->
    !sh_q[7] && sh_q[2]) else $error("done outside burst cell mode");
  a_lock_enabled: assert property (wb_ack_o && !wb_we_i && wb_dat_o[0]
    |-> sh_q[4]) else $error("lock while disabled");
  a_oh_gated: assert property ($rose(overhead_take) |-> ##[0:1]
    (sh_q[6] && !sh_q[7])) else $error("overhead taken wrongly");
  a_gen_start: assert property ($rose(sh_q[4]) |-> ##[0:2]
    tx_pattern_valid) else $error("generator did not start");
  a_gen_stop: assert property ($fell(sh_q[4]) |-> ##[0:1]
    !tx_pattern_valid) else $error("generator did not stop");
  a_err_enabled: assert property (error_event |-> sh_q[4] ||
    $past(sh_q[4])) else $error("error counted while disabled");
endmodule // tcp_test_ctl_chk

bind tcp_test_ctl tcp_test_ctl_chk i_chk (.clock, .srst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .tx_pattern_valid, .overhead_take, .error_event);

// [test/test_test_cell_prbs_control.sv]
// Purpose: directed bench for the test control block
// Assumes: generator looped back to the receiver by the bench
// Notes:   long bursts are not run to completion
`timescale 1ns/10ps
module test_test_cell_prbs_control;
  // ****************************************************************
  // signals, tasks and sequence
  // ****************************************************************
  localparam logic [7:0] CSR = tcp_pkg::CSR_ADDR;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, rx_pattern_in = 1'b0, rx_pattern_valid = 1'b0;
  logic        tx_serial_payload_in = 1'b0, tx_pattern_out, tx_pattern_valid;
  logic        cell_start, overhead_take, overhead_bit, error_event, flip = 1'b0;
  logic [15:0] error_count, rd_q;
  int          bad_count = 0, n_tests = 0;
  int          n_err = 0, n_cells = 0, n_bits = 0;
  // reference history of the sent stream, x^15 + x^14 + 1 prediction
  logic [14:0] tx_hist = 15'h0000;
  wire logic   tx_pred = tx_hist[14] ^ tx_hist[13];

  tcp_test_ctl i_dut (.clock, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_pattern_in,
    .rx_pattern_valid, .tx_serial_payload_in, .tx_pattern_out,
    .tx_pattern_valid, .cell_start, .overhead_take, .overhead_bit,
    .error_event, .error_count);

  always #12.5 clock = ~clock;
  // loopback; flip corrupts exactly one bit to count a known error burst
  always @(posedge clock) begin
    rx_pattern_in <= tx_pattern_out ^ flip;
    rx_pattern_valid <= tx_pattern_valid;
    tx_serial_payload_in <= ~tx_serial_payload_in;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // classic single cycle; held until ack is seen at a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, d};
    // no local limit: only the watchdog ends a wait for ack
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog: the sequence needs about 1900 cycles
  initial begin
    #(25 * 10000);
    bad_count++;
    end_sim;
  end

  initial begin
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    wb(0, CSR, 8'h00);
    chk(rd_q, 16'h0000);
    wb(1, 8'h1C, 8'hFF);
    wb(0, 8'h1C, 8'h00);
    chk(rd_q, 16'h0000);
    // read-only bits ignore writes; overhead path follows mode
    wb(1, CSR, 8'h6B);
    wb(0, CSR, 8'h00);
    chk(rd_q, 16'h0048);
    chk(overhead_take, 16'h0001);
    // serial input toggles each clock; three flops of delay invert it
    chk(overhead_bit, {15'h0000, ~tx_serial_payload_in});
    wb(1, CSR, 8'hC8);
    wb(0, CSR, 8'h00);
    chk(overhead_take, 16'h0000);
    chk(overhead_bit, 16'h0000);
    // clear-channel pattern locks, then one bad bit gives three hits
    wb(1, CSR, 8'h90);
    repeat (100) @(posedge clock);
    wb(0, CSR, 8'h00);
    chk(rd_q, 16'h0091);
    chk(tx_pattern_valid, 16'h0001);
    flip <= 1'b1;
    @(posedge clock);
    flip <= 1'b0;
    repeat (40) begin
      @(posedge clock);
      if (error_event === 1'b1) n_err++;
    end
    chk(error_count, 16'h0003);
    chk(n_err[15:0], 16'h0003);
    wb(1, CSR, 8'h80);
    wb(0, CSR, 8'h00);
    chk(rd_q, 16'h0080);
    chk(tx_pattern_valid, 16'h0000);
    // cell mode, continuous over several 384-clock cells
    wb(1, CSR, 8'h10);
    repeat (1200) begin
      @(posedge clock);
      if (cell_start === 1'b1) n_cells++;
      if (tx_pattern_valid === 1'b1) begin
        if (n_bits >= 15) chk(tx_pattern_out, tx_pred);
        tx_hist = {tx_hist[13:0], tx_pattern_out};
        n_bits++;
      end
    end
    chk(n_cells[15:0], 16'h0004);
    wb(0, CSR, 8'h00);
    chk(rd_q, 16'h0011);
    chk(error_count, 16'h0000);
    chk(tx_pattern_valid, 16'h0001);
    // burst start: done flag low while cells still flow
    wb(1, CSR, 8'h00);
    wb(1, CSR, 8'h14);
    repeat (500) @(posedge clock);
    wb(0, CSR, 8'h00);
    chk(rd_q, 16'h0015);
    chk(tx_pattern_valid, 16'h0001);
    end_sim;
  end
endmodule // test_test_cell_prbs_control
